// ---- design/twm_defs.vh ----
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH

// ****************************************
// Widths and counts
// ****************************************
`define TWM_RATE_W      7
`define TWM_BYTE_W      8
`define TWM_FIFO_DEPTH  8
`define TWM_LAST_DATA   4'h7
`define TWM_ACK_SLOT    4'h8

// ****************************************
// Reset values
// ****************************************
`define TWM_RATE_RST    7'h00
`define TWM_BYTE_RST    8'h00
`define TWM_BIT_RST     4'h0
`define TWM_STATE_RST   4'h0

`endif

// ---- design/twm_fifo.v ----
`timescale 1ns/100ps
`include "twm_defs.vh"

module twm_fifo #(
  parameter WIDTH = `TWM_BYTE_W,
  parameter DEPTH = `TWM_FIFO_DEPTH
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;

  wire doPush = inValid && inReady;
  wire doPop  = outValid && outReady;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q];

  // Pointers wrap by hand so a depth that is not a power of two still works
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doPush)
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      if (doPop)
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      if (doPush && !doPop)
        count_q <= count_q + 1'b1;
      else if (doPop && !doPush)
        count_q <= count_q - 1'b1;
    end
  end

  always @(posedge clk) begin
    if (doPush)
      mem[wrPtr_q] <= inData;
  end
endmodule // twm_fifo

// ---- design/twm_sequencer.v ----
`timescale 1ns/100ps
`include "twm_defs.vh"

module twm_sequencer #(
  parameter RATE_W     = `TWM_RATE_W,
  parameter FIFO_DEPTH = `TWM_FIFO_DEPTH
) (
  input  wire              clk,
  input  wire              rstn,
  input  wire [RATE_W-1:0] rateReload,
  input  wire              ackDataValue,
  input  wire              ackSeqSet,
  input  wire              stopSet,
  input  wire              receiveSet,
  input  wire              txWrite,
  input  wire [7:0]        txByte,
  output wire              rxValid,
  output wire [7:0]        rxByte,
  input  wire              rxRead,
  input  wire              irqClear,
  input  wire              collisionClear,
  input  wire              overflowClear,
  input  wire              stopDetClear,
  input  wire              portIrqEnable,
  output wire              ackSequenceEnable,
  output wire              stopEnable,
  output wire              receiveEnable,
  output wire              bufferFull,
  output wire              writeCollision,
  output wire              receiveOverflow,
  output wire              ackStatus,
  output wire              stopDetected,
  output wire              portIrqFlag,
  output wire              portIrq,
  input  wire              sclIn,
  output wire              sclOut,
  output wire              sclOe,
  input  wire              sdaIn,
  output wire              sdaOut,
  output wire              sdaOe
);
  // ****************************************
  // States
  // ****************************************
  localparam S_IDLE    = 4'h0;
  localparam S_ACK_LO  = 4'h1;
  localparam S_ACK_WH  = 4'h2;
  localparam S_ACK_HI  = 4'h3;
  localparam S_ACK_END = 4'h4;
  localparam S_STP_SDA = 4'h5;
  localparam S_STP_LO  = 4'h6;
  localparam S_STP_WH  = 4'h7;
  localparam S_STP_HI  = 4'h8;
  localparam S_STP_DET = 4'h9;
  localparam S_STP_END = 4'hA;
  localparam S_BIT_LO  = 4'hB;
  localparam S_BIT_WH  = 4'hC;
  localparam S_BIT_HI  = 4'hD;

  // A zero rate field would wrap round and take the longest count, so it behaves as one
  function [RATE_W-1:0] rateLoad;
    input [RATE_W-1:0] r;
    begin
      rateLoad = (r == {RATE_W{1'b0}}) ? {{(RATE_W-1){1'b0}}, 1'b1} : r;
    end
  endfunction

  reg [3:0]        state_q;
  reg [RATE_W-1:0] rateCnt_q;
  reg              rateRun_q;
  reg [3:0]        bitCnt_q;
  reg              txMode_q;
  reg [7:0]        shift_q;
  reg              sclOe_q;
  reg              sdaOe_q;
  reg              ack_sequence_enable_q;
  reg              stopEn_q;
  reg              rcvEn_q;
  reg              bufFull_q;
  reg              write_collision_flag_q;
  reg              ovf_q;
  reg              ack_status_bit_q;
  reg              stopDet_q;
  reg              irqFlag_q;
  reg              sclMeta_q;
  reg              sclSync_q;
  reg              sdaMeta_q;
  reg              sdaSync_q;
  reg              push_q;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
    end else begin
      sclMeta_q <= sclIn;
      sclSync_q <= sclMeta_q;
      sdaMeta_q <= sdaIn;
      sdaSync_q <= sdaMeta_q;
    end
  end

  wire rateOvf    = rateRun_q && (rateCnt_q == {{(RATE_W-1){1'b0}}, 1'b1});
  wire busy       = (state_q != S_IDLE) || ack_sequence_enable_q || stopEn_q || rcvEn_q;
  wire fifoReady;
  wire rxDone     = push_q;
  wire readPop    = rxRead && rxValid;

  // ****************************************
  // Received byte queue
  // ****************************************
  twm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_twm_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (push_q),
    .inReady  (fifoReady),
    .inData   (shift_q),
    .outValid (rxValid),
    .outReady (rxRead),
    .outData  (rxByte)
  );

  // ****************************************
  // Sequencer and rate counter
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= `TWM_STATE_RST;
      rateCnt_q <= `TWM_RATE_RST;
      rateRun_q <= 1'b0;
      bitCnt_q  <= `TWM_BIT_RST;
      txMode_q  <= 1'b0;
      shift_q   <= `TWM_BYTE_RST;
      sclOe_q   <= 1'b0;
      sdaOe_q   <= 1'b0;
      ack_sequence_enable_q   <= 1'b0;
      stopEn_q  <= 1'b0;
      rcvEn_q   <= 1'b0;
      ack_status_bit_q <= 1'b0;
      push_q    <= 1'b0;
    end else begin
      push_q <= 1'b0;
      // Counter runs down to one, flags overflow and parks
      if (rateOvf) begin
        rateRun_q <= 1'b0;
        rateCnt_q <= {RATE_W{1'b0}};
      end else if (rateRun_q) begin
        rateCnt_q <= rateCnt_q - 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (!busy && ackSeqSet) begin
            ack_sequence_enable_q <= 1'b1;
          end else if (!busy && stopSet) begin
            stopEn_q <= 1'b1;
          end else if (!busy && receiveSet) begin
            rcvEn_q <= 1'b1;
          end else if (ack_sequence_enable_q) begin
            sclOe_q   <= 1'b1;
            sdaOe_q   <= ~ackDataValue;
            rateCnt_q <= rateLoad(rateReload);
            rateRun_q <= 1'b1;
            state_q   <= S_ACK_LO;
          end else if (stopEn_q) begin
            sclOe_q <= 1'b1;
            sdaOe_q <= 1'b1;
            state_q <= S_STP_SDA;
          end else if (rcvEn_q && fifoReady) begin
            // Start waits while the queue is full, so no byte is ever dropped
            sclOe_q   <= 1'b1;
            sdaOe_q   <= 1'b0;
            txMode_q  <= 1'b0;
            bitCnt_q  <= `TWM_BIT_RST;
            rateCnt_q <= rateLoad(rateReload);
            rateRun_q <= 1'b1;
            state_q   <= S_BIT_LO;
          end else if (txWrite && !busy) begin
            sclOe_q   <= 1'b1;
            sdaOe_q   <= ~txByte[7];
            shift_q   <= {txByte[6:0], 1'b0};
            txMode_q  <= 1'b1;
            bitCnt_q  <= `TWM_BIT_RST;
            rateCnt_q <= rateLoad(rateReload);
            rateRun_q <= 1'b1;
            state_q   <= S_BIT_LO;
          end
        end
        S_ACK_LO: if (rateOvf) begin
          sclOe_q <= 1'b0;
          state_q <= S_ACK_WH;
        end
        S_ACK_WH: if (sclSync_q) begin
          rateCnt_q <= rateLoad(rateReload);
          rateRun_q <= 1'b1;
          state_q   <= S_ACK_HI;
        end
        S_ACK_HI: if (rateOvf) begin
          sclOe_q   <= 1'b1;
          ack_sequence_enable_q   <= 1'b0;
          rateCnt_q <= rateLoad(rateReload);
          rateRun_q <= 1'b1;
          state_q   <= S_ACK_END;
        end
        S_ACK_END: if (rateOvf) begin
          sdaOe_q <= 1'b0;
          state_q <= S_IDLE;
        end
        S_STP_SDA: if (!sdaSync_q) begin
          rateCnt_q <= rateLoad(rateReload);
          rateRun_q <= 1'b1;
          state_q   <= S_STP_LO;
        end
        S_STP_LO: if (rateOvf) begin
          sclOe_q <= 1'b0;
          state_q <= S_STP_WH;
        end
        S_STP_WH: if (sclSync_q) begin
          rateCnt_q <= rateLoad(rateReload);
          rateRun_q <= 1'b1;
          state_q   <= S_STP_HI;
        end
        S_STP_HI: if (rateOvf) begin
          sdaOe_q <= 1'b0;
          state_q <= S_STP_DET;
        end
        S_STP_DET: if (sdaSync_q && sclSync_q) begin
          rateCnt_q <= rateLoad(rateReload);
          rateRun_q <= 1'b1;
          state_q   <= S_STP_END;
        end
        S_STP_END: if (rateOvf) begin
          stopEn_q <= 1'b0;
          state_q  <= S_IDLE;
        end
        S_BIT_LO: if (rateOvf) begin
          sclOe_q <= 1'b0;
          state_q <= S_BIT_WH;
        end
        S_BIT_WH: if (sclSync_q) begin
          // Slave may stretch SCL; the high phase only starts once it is seen high
          rateCnt_q <= rateLoad(rateReload);
          rateRun_q <= 1'b1;
          if (!txMode_q)
            shift_q <= {shift_q[6:0], sdaSync_q};
          state_q <= S_BIT_HI;
        end
        S_BIT_HI: if (rateOvf) begin
          sclOe_q  <= 1'b1;
          bitCnt_q <= bitCnt_q + 4'h1;
          if (txMode_q && bitCnt_q == `TWM_ACK_SLOT) begin
            ack_status_bit_q <= sdaSync_q;
            state_q   <= S_IDLE;
          end else if (!txMode_q && bitCnt_q == `TWM_LAST_DATA) begin
            rcvEn_q <= 1'b0;
            push_q  <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            if (txMode_q && bitCnt_q == `TWM_LAST_DATA) begin
              sdaOe_q <= 1'b0;
            end else if (txMode_q) begin
              sdaOe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end
            rateCnt_q <= rateLoad(rateReload);
            rateRun_q <= 1'b1;
            state_q   <= S_BIT_LO;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Status flags; a hardware set wins over a clear
  // ****************************************
  wire txStart  = (state_q == S_IDLE) && txWrite && !busy && !ackSeqSet && !stopSet
                  && !receiveSet;
  wire txDrain  = (state_q == S_BIT_HI) && rateOvf && txMode_q
                  && (bitCnt_q == `TWM_LAST_DATA);
  wire ackDone  = (state_q == S_BIT_HI) && rateOvf && txMode_q
                  && (bitCnt_q == `TWM_ACK_SLOT);
  wire stopSeen = (state_q == S_STP_DET) && sdaSync_q && sclSync_q;
  wire stopDone = (state_q == S_STP_END) && rateOvf;
  wire ackTxEnd = (state_q == S_ACK_END) && rateOvf;
  wire irqSet   = ackDone || rxDone || stopDone || ackTxEnd;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bufFull_q <= 1'b0;
      write_collision_flag_q    <= 1'b0;
      ovf_q     <= 1'b0;
      stopDet_q <= 1'b0;
      irqFlag_q <= 1'b0;
    end else begin
      if (txStart || rxDone)
        bufFull_q <= 1'b1;
      else if (txDrain || (readPop && !txMode_q))
        bufFull_q <= 1'b0;
      if (txWrite && !txStart)
        write_collision_flag_q <= 1'b1;
      else if (collisionClear)
        write_collision_flag_q <= 1'b0;
      if (rxDone && bufFull_q && !readPop)
        ovf_q <= 1'b1;
      else if (overflowClear)
        ovf_q <= 1'b0;
      if (stopSeen)
        stopDet_q <= 1'b1;
      else if (stopDetClear)
        stopDet_q <= 1'b0;
      if (irqSet)
        irqFlag_q <= 1'b1;
      else if (irqClear)
        irqFlag_q <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sclOut            = 1'b0;
  assign sdaOut            = 1'b0;
  assign sclOe             = sclOe_q;
  assign sdaOe             = sdaOe_q;
  assign ackSequenceEnable = ack_sequence_enable_q;
  assign stopEnable        = stopEn_q;
  assign receiveEnable     = rcvEn_q;
  assign bufferFull        = bufFull_q;
  assign writeCollision    = write_collision_flag_q;
  assign receiveOverflow   = ovf_q;
  assign ackStatus         = ack_status_bit_q;
  assign stopDetected      = stopDet_q;
  assign portIrqFlag       = irqFlag_q;
  assign portIrq           = irqFlag_q && portIrqEnable;
endmodule // twm_sequencer

// ---- bench/twm_props.sv ----
`timescale 1ns/100ps
module twm_props #(
  parameter RATE_W = 7
) (
  input wire              clk,
  input wire              rstn,
  input wire [RATE_W-1:0] rateReload,
  input wire              ackDataValue,
  input wire              txWrite,
  input wire              rxRead,
  input wire              rxValid,
  input wire              portIrqEnable,
  input wire              ackSequenceEnable,
  input wire              stopEnable,
  input wire              receiveEnable,
  input wire              bufferFull,
  input wire              writeCollision,
  input wire              receiveOverflow,
  input wire              stopDetected,
  input wire              portIrqFlag,
  input wire              portIrq,
  input wire              sclIn,
  input wire              sclOe,
  input wire              sdaIn,
  input wire              sdaOe
);
  // ****************************************
  // SCL high-time counter
  // ****************************************
  // Saturates so a long idle bus never wraps back below the rate field
  reg [7:0] hiCnt_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      hiCnt_q <= 8'hff;
    else if (sclOe || !sclIn)
      hiCnt_q <= 8'h00;
    else if (hiCnt_q != 8'hff)
      hiCnt_q <= hiCnt_q + 8'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  ack_start_a: assert property (
    $rose(ackSequenceEnable) |=> sclOe && (sdaOe == !ackDataValue))
    else $error("ack slot drive wrong");
  ack_end_a: assert property (
    $fell(ackSequenceEnable) |-> ##[0:1] sclOe ##[1:140] portIrqFlag)
    else $error("ack sequence end wrong");
  stop_start_a: assert property (
    $rose(stopEnable) |=> sdaOe && sclOe)
    else $error("stop did not pull lines low");
  stop_seen_a: assert property (
    $rose(stopDetected) |-> sclIn && sdaIn && !sclOe && !sdaOe)
    else $error("stop flagged with bus not high");
  stop_end_a: assert property (
    $fell(stopEnable) |-> ##[0:1] portIrqFlag)
    else $error("stop end without irq");
  busy_write_a: assert property (
    txWrite && (ackSequenceEnable || stopEnable || receiveEnable || (bufferFull && !rxValid))
    |=> writeCollision)
    else $error("busy write not flagged");
  scl_high_a: assert property (
    $rose(sclOe) |-> $past(hiCnt_q) >= 8'(rateReload))
    else $error("scl high time too short");
  irq_gate_a: assert property (
    portIrq == (portIrqFlag && portIrqEnable))
    else $error("irq gating wrong");
  tx_release_a: assert property (
    $fell(bufferFull) && !$past(rxRead) |-> ##[0:1] !sdaOe)
    else $error("sda held after eighth bit");
  rx_done_a: assert property (
    $fell(receiveEnable) |-> ##[1:2] (bufferFull && portIrqFlag))
    else $error("receive end wrong");
  rx_over_a: assert property (
    $rose(receiveOverflow) |-> $past(bufferFull))
    else $error("overflow without full buffer");

  cover property ($fell(ackSequenceEnable));
  cover property ($fell(stopEnable));
  cover property ($rose(receiveOverflow));
endmodule // twm_props

bind twm_sequencer twm_props #(.RATE_W(RATE_W)) u_twm_props (.clk, .rstn, .rateReload,
  .ackDataValue, .txWrite, .rxRead, .rxValid, .portIrqEnable, .ackSequenceEnable, .stopEnable,
  .receiveEnable, .bufferFull, .writeCollision, .receiveOverflow, .stopDetected, .portIrqFlag,
  .portIrq, .sclIn, .sclOe, .sdaIn, .sdaOe);

// ---- bench/twm_slave.sv ----
`timescale 1ns/100ps
module twm_slave (
  input  wire       clk,
  input  wire       scl,
  input  wire       sda,
  input  wire       arm,
  input  wire       rdMode,
  input  wire       nack,
  input  wire [7:0] txData,
  input  wire [3:0] stretch,
  output wire       sclLow,
  output reg        sdaLow,
  output reg  [7:0] rxData
);
  // ****************************************
  // Open-drain slave, edges seen on the wire
  // ****************************************
  reg       sclPrev;
  reg [3:0] bitCnt;
  reg [3:0] holdCnt;
  initial begin
    sclPrev = 1'b1;
    bitCnt = 4'h9;
    holdCnt = 4'h0;
    sdaLow = 1'b0;
    rxData = 8'h00;
  end
  // Stretching extends the low phase after each fall
  assign sclLow = holdCnt != 4'h0;
  always @(posedge clk) begin
    sclPrev <= scl;
    if (arm) begin
      bitCnt <= 4'h0;
      sdaLow <= rdMode & ~txData[7];
    end else if (scl && !sclPrev) begin
      if (bitCnt < 4'h9)
        bitCnt <= bitCnt + 4'h1;
      if (!rdMode && bitCnt < 4'h8)
        rxData <= {rxData[6:0], sda};
    end else if (!scl && sclPrev) begin
      holdCnt <= stretch;
      if (rdMode)
        sdaLow <= (bitCnt < 4'h8) & ~txData[3'h7 - bitCnt[2:0]];
      else
        sdaLow <= (bitCnt == 4'h8) & ~nack;
    end else if (holdCnt != 4'h0) begin
      holdCnt <= holdCnt - 4'h1;
    end
  end
endmodule // twm_slave

// ---- bench/twm_sequencer_bench.sv ----
`timescale 1ns/100ps
module twm_sequencer_bench;
  // ****************************************
  // Wiring
  // ****************************************
  logic       clk, rstn, ackDataValue, ackSeqSet, stopSet, receiveSet, txWrite, rxRead;
  logic       irqClear, collisionClear, overflowClear, stopDetClear, portIrqEnable;
  logic       sArm, sRd, sNack;
  logic [6:0] rateReload;
  logic [7:0] txByte, sTx;
  logic [3:0] sStretch;
  wire        rxValid, ackSequenceEnable, stopEnable, receiveEnable, bufferFull;
  wire        writeCollision, receiveOverflow, ackStatus, stopDetected, portIrqFlag, portIrq;
  wire        sclOe, sdaOe, sSclLow, sSdaLow;
  wire  [7:0] rxByte, sRx;
  wire        sclIn = ~(sclOe | sSclLow);
  wire        sdaIn = ~(sdaOe | sSdaLow);
  integer     miscompares, nChecks;

  twm_sequencer u_twm_sequencer (.clk, .rstn, .rateReload, .ackDataValue, .ackSeqSet, .stopSet,
    .receiveSet, .txWrite, .txByte, .rxValid, .rxByte, .rxRead, .irqClear, .collisionClear,
    .overflowClear, .stopDetClear, .portIrqEnable, .ackSequenceEnable, .stopEnable,
    .receiveEnable, .bufferFull, .writeCollision, .receiveOverflow, .ackStatus, .stopDetected,
    .portIrqFlag, .portIrq, .sclIn, .sclOut(), .sclOe, .sdaIn, .sdaOut(), .sdaOe);
  twm_slave u_twm_slave (.clk, .scl(sclIn), .sda(sdaIn), .arm(sArm), .rdMode(sRd), .nack(sNack),
    .txData(sTx), .stretch(sStretch), .sclLow(sSclLow), .sdaLow(sSdaLow), .rxData(sRx));

  always #20 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nChecks = nChecks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task wait_irq;
    int i;
    i = 0;
    while (portIrqFlag !== 1'b1 && i < 3000) begin
      tick(1);
      i = i + 1;
    end
    check("irq wait", 8'(portIrqFlag), 8'h01);
  endtask

  task clear_flags;
    {irqClear, collisionClear, overflowClear, stopDetClear} = 4'hf;
    tick(1);
    {irqClear, collisionClear, overflowClear, stopDetClear} = 4'h0;
    tick(1);
    check("clear", 8'({portIrqFlag, writeCollision}), 8'h00);
    check("clear status", 8'({receiveOverflow, stopDetected}), 8'h00);
  endtask

  task report_and_stop;
    $display("Checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_write(input logic [7:0] b, input logic nk, input logic [3:0] st);
    {sNack, sStretch, sRd, sArm, txByte, txWrite} = {nk, st, 1'b0, 1'b1, b, 1'b1};
    tick(1);
    {sArm, txWrite} = 2'h0;
    tick(1);
    check("full", 8'(bufferFull), 8'h01);
    {txByte, txWrite} = {~b, 1'b1};
    tick(1);
    txWrite = 1'b0;
    tick(1);
    check("collision", 8'(writeCollision), 8'h01);
    wait_irq;
    check("slave byte", sRx, b);
    check("ack status", 8'(ackStatus), 8'(nk));
    check("tx end", 8'({bufferFull, sclOe, sdaOe, portIrq}), 8'h04);
    clear_flags;
  endtask

  task t_ack(input logic v);
    time t0;
    int  n;
    {ackDataValue, ackSeqSet} = {v, 1'b1};
    tick(1);
    ackSeqSet = 1'b0;
    tick(2);
    check("ack drive", 8'({sclOe, sdaOe}), 8'({1'b1, ~v}));
    t0 = $time;
    wait_irq;
    // Three rate periods, plus up to four cycles of pin synchronising
    n = int'(($time - t0) / 40) - 3 * rateReload;
    check("ack length", 8'(n >= 0 && n <= 4), 8'h01);
    check("ack end", 8'({ackSequenceEnable, sclOe}), 8'h01);
    clear_flags;
  endtask

  task t_rx;
    int i;
    for (i = 0; i < 9; i++) begin
      {sTx, sRd, sArm} = {8'h10 + 8'(i), 2'h3};
      tick(1);
      {sArm, receiveSet} = 2'h1;
      tick(1);
      receiveSet = 1'b0;
      if (i < 8) begin
        wait_irq;
        check("rx end", 8'({receiveEnable, bufferFull}), 8'h01);
        irqClear = 1'b1;
        tick(1);
        irqClear = 1'b0;
      end
    end
    check("overflow", 8'(receiveOverflow), 8'h01);
    tick(60);
    check("fifo full wait", 8'({receiveEnable, portIrqFlag}), 8'h02);
    // A write while the receive waits must be refused, not start a byte
    {txByte, txWrite} = 9'h001;
    tick(1);
    txWrite = 1'b0;
    tick(1);
    check("rx busy write", 8'({writeCollision, sdaOe}), 8'h02);
    for (i = 0; i < 9; i++) begin
      if (i == 8)
        wait_irq;
      check("rx byte", rxByte, 8'h10 + 8'(i));
      rxRead = 1'b1;
      tick(1);
      rxRead = 1'b0;
      tick(1);
      check("read clears full", 8'(bufferFull), 8'h00);
    end
    check("empty", 8'({rxValid, receiveEnable}), 8'h00);
    clear_flags;
  endtask

  task t_stop;
    {portIrqEnable, stopSet} = 2'h3;
    tick(1);
    stopSet = 1'b0;
    tick(2);
    check("stop drive", 8'({sclOe, sdaOe}), 8'h03);
    wait_irq;
    check("stop flags", 8'({stopDetected, stopEnable, portIrq}), 8'h05);
    check("stop pins", 8'({sclIn, sdaIn}), 8'h03);
    clear_flags;
  endtask

  initial begin
    {clk, rstn, ackDataValue, ackSeqSet, stopSet, receiveSet, txWrite, rxRead} = 8'h00;
    {irqClear, collisionClear, overflowClear, stopDetClear, portIrqEnable} = 5'h00;
    {sArm, sRd, sNack, txByte, sTx, sStretch} = 23'h00_0000;
    rateReload = 7'h04;
    miscompares = 0;
    nChecks = 0;
    tick(20);
    rstn = 1'b1;
    tick(1);
    check("reset flags", 8'({bufferFull, writeCollision, portIrqFlag}), 8'h00);
    check("reset pins", 8'({sclOe, sdaOe, rxValid}), 8'h00);
    t_write(8'ha5, 1'b0, 4'h0);
    t_write(8'h3c, 1'b1, 4'h6);
    t_ack(1'b0);
    // A second rate shows the reload field really sets the timing
    rateReload = 7'h06;
    t_ack(1'b1);
    t_rx;
    t_stop;
    report_and_stop;
  end

  // Byte times run near 150 cycles; this leaves ample margin
  initial begin
    #(40 * 10000);
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // twm_sequencer_bench
